// *** bench/ccs_batt_model.sv ***
// Behavioural battery and adapter that drive the sequencer's sense levels.
`timescale 1ns/10ps
module ccs_batt_model
  import ccs_pkg::*;
(
  input  wire logic       aclk,  // Clock.
  input  wire ccs_drive_t drv,   // Power stage controls.
  input  wire logic       drain, // Empties the battery.
  input  wire logic [6:0] lim,   // Limit, pin and fault levels, mapped below.
  output ccs_sense_t      sense  // Levels to the sequencer.
);
  int vbat = 0;
  always @(posedge aclk) begin
    if (drain) begin
      vbat <= 0;
    end else if (drv.charge_current_ma != 12'h000 && vbat < 100) begin
      vbat <= vbat + 1;
    end
  end
  always_comb begin
    sense                = '0;
    sense.conv_ready     = 1'b1;
    sense.below_short    = vbat < 20;
    sense.below_lowv     = vbat < 40;
    sense.cv_loop        = vbat >= 60;
    sense.below_term     = vbat >= 80;
    sense.below_rechg    = vbat < 70;
    sense.below_depl     = vbat < 5;
    sense.in_sag_v       = lim[0];
    sense.in_over_i      = lim[1];
    sense.vsys_below_bat = lim[2];
    sense.thermal_reg    = lim[3];
    sense.ce_n           = lim[4];
    sense.ts_fault       = lim[5];
    sense.vsys_below_min = lim[6];
  end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the charge cycle sequencer.
`timescale 1ns/10ps
module tb
  import ccs_pkg::*;
;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, drain = 0;
  logic [3:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rd;
  logic [6:0]  lim = '0;
  logic [3:0]  wstrb = 4'hf;
  wire         awready, wready, bvalid, arready, rvalid, stat, stat_oe_n, phase_int;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [2:0]  code;
  ccs_sense_t  sense;
  ccs_drive_t  drv;
  int          err_total = 0, comparisons = 0, seed = 32'h1b20;
  logic [2:0]  exp_q[$];
  logic [15:0] vt[4] = '{CCS_V_1S_MV, CCS_V_2S_MV, CCS_V_3S_MV, CCS_V_4S_MV};
  logic [11:0] ima[8] = '{12'h0, CCS_I_TRICKLE_MA, CCS_I_PRE_MA, CCS_I_FAST_LO_MA,
                          CCS_I_FAST_LO_MA, 12'h0, CCS_I_FAST_LO_MA, 12'h0};
  always #10 aclk = ~aclk;
  ccs_sequencer #(.TICK_CYCLES(10), .TRICKLE_MS(200), .PRE_MS(200), .FAST_MS(200),
    .TOPOFF_MS(20), .BLINK_MS(2)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sense_i(sense), .drive_o(drv), .stat_o(stat), .stat_oe_n(stat_oe_n),
    .charge_phase_code(code), .phase_int(phase_int));
  ccs_batt_model i_batt (.aclk(aclk), .drv(drv), .drain(drain), .lim(lim), .sense(sense));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    check(32'(bresp), 32'(CCS_RESP_OKAY));
    bready <= 0;
  endtask
  task automatic rdr(input logic [3:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rd = rdata;
    check(32'(rresp), 32'(CCS_RESP_OKAY));
    rready <= 0;
  endtask
  task automatic wait_q;
    while (exp_q.size() != 0) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    if (phase_int === 1'b1) begin
      check(32'(code), 32'(exp_q.size() ? exp_q.pop_front() : CCS_PH_RSVD));
      check(32'(stat_oe_n), 32'(code == 0 || code == 7));
      check(32'(stat), 32'h0);
      check(32'(drv.charge_current_ma), 32'(ima[code]));
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish;
  end
  initial begin
    exp_q = '{1, 2, 3, 4, 7};
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rdr(CCS_OFS_CTRL);
    check(rd, 32'h05);
    wait_q;
    for (int c = 0; c < 4; c++) begin
      wr(CCS_OFS_CTRL, 32'h05 | (c << 6) | (c << 4));
      rdr(CCS_OFS_DEFAULTS);
      check(rd, {vt[c], 4'h0, c < 2 ? CCS_I_FAST_LO_MA : CCS_I_FAST_HI_MA});
      check(32'(drv.recharge_threshold_sel), 32'(c));
    end
    wr(CCS_OFS_CTRL, 32'h05);
    wstrb <= 4'he;
    wr(CCS_OFS_CTRL, 32'h00);
    wstrb <= 4'hf;
    rdr(CCS_OFS_CTRL);
    check(rd, 32'h05);
    repeat (4) begin
      lim <= 7'($random(seed) & 3);
      repeat (4) @(posedge aclk);
      rdr(CCS_OFS_STATUS);
      check(32'(rd[4:3]), 32'(lim[1:0]));
      check(32'({drv.input_current_limit_loop, drv.input_voltage_limit_loop}), 32'(lim[1:0]));
    end
    lim <= 0;
    exp_q = '{0, 1, 2, 3, 4, 7};
    @(posedge aclk) drain <= 1;
    @(posedge aclk) drain <= 0;
    wait_q;
    exp_q = '{0, 3, 4, 7};
    wr(CCS_OFS_CTRL, 32'h04);
    repeat (6) @(posedge aclk);
    lim <= 7'h4a;
    wr(CCS_OFS_CTRL, 32'h05);
    repeat (12) @(posedge aclk);
    check(32'(code), 32'(CCS_PH_TAPER));
    check(32'(drv.reduce_current), 32'h1);
    check(32'(stat_oe_n), 32'h0);
    wr(CCS_OFS_CTRL, 32'h07);
    @(posedge aclk);
    check(32'(stat_oe_n), 32'h1);
    wr(CCS_OFS_CTRL, 32'h05);
    lim <= 0;
    wait_q;
    exp_q = '{0, 3, 4, 7};
    lim <= 7'h30;
    repeat (8) @(posedge aclk);
    lim <= 7'h20;
    repeat (8) @(posedge aclk);
    check(32'(code), 32'(CCS_PH_NONE));
    lim <= 0;
    wait_q;
    lim <= 7'h04;
    repeat (5) @(posedge aclk);
    rdr(CCS_OFS_STATUS);
    check(32'({rd[8], rd[5]}), 32'h3);
    tally_and_finish;
  end
endmodule

// *** verilog/ccs_pkg.sv ***
// Package of constants and carrier types for the charge cycle sequencer.
package ccs_pkg;
  // Register byte offsets.
  localparam logic [3:0] CCS_OFS_CTRL     = 4'h0;
  localparam logic [3:0] CCS_OFS_STATUS   = 4'h4;
  localparam logic [3:0] CCS_OFS_DEFAULTS = 4'h8;
  localparam logic [3:0] CCS_OFS_TIMER    = 4'hc;
  // Control register fields.
  localparam int CCS_CTRL_EN      = 0;
  localparam int CCS_CTRL_STATDIS = 1;
  localparam int CCS_CTRL_HALF    = 2;
  localparam int CCS_CTRL_TOPOFF  = 3;
  localparam int CCS_CTRL_RCH_LSB = 4;
  localparam int CCS_CTRL_CELL_LSB = 6;
  localparam logic [7:0] CCS_CTRL_RESET = 8'h05;
  // Status register fields.
  localparam int CCS_ST_PHASE_LSB = 0;
  localparam int CCS_ST_VLIM      = 3;
  localparam int CCS_ST_ILIM      = 4;
  localparam int CCS_ST_BATSW     = 5;
  localparam int CCS_ST_TSFLT     = 6;
  localparam int CCS_ST_TMRFLT    = 7;
  localparam int CCS_ST_SUPPL     = 8;
  // Phase codes.
  localparam logic [2:0] CCS_PH_NONE    = 3'h0;
  localparam logic [2:0] CCS_PH_TRICKLE = 3'h1;
  localparam logic [2:0] CCS_PH_PRE     = 3'h2;
  localparam logic [2:0] CCS_PH_FAST    = 3'h3;
  localparam logic [2:0] CCS_PH_TAPER   = 3'h4;
  localparam logic [2:0] CCS_PH_RSVD    = 3'h5;
  localparam logic [2:0] CCS_PH_TOPOFF  = 3'h6;
  localparam logic [2:0] CCS_PH_DONE    = 3'h7;
  // Currents in mA and voltages in mV.
  localparam logic [11:0] CCS_I_TRICKLE_MA = 12'h064;
  localparam logic [11:0] CCS_I_PRE_MA     = 12'h078;
  localparam logic [11:0] CCS_I_FAST_LO_MA = 12'h7d0;
  localparam logic [11:0] CCS_I_FAST_HI_MA = 12'h3e8;
  localparam logic [15:0] CCS_V_1S_MV      = 16'h1068;
  localparam logic [15:0] CCS_V_2S_MV      = 16'h20d0;
  localparam logic [15:0] CCS_V_3S_MV      = 16'h3138;
  localparam logic [15:0] CCS_V_4S_MV      = 16'h41a0;
  // Timing: clock rate, tick length in us and timer lengths in hours or ms.
  localparam int CCS_CLK_MHZ       = 50;
  localparam int CCS_TICK_US       = 1000;
  localparam int CCS_TICK_CYCLES   = CCS_TICK_US * CCS_CLK_MHZ;
  localparam int CCS_TRICKLE_HOURS = 1;
  localparam int CCS_PRE_HOURS     = 2;
  localparam int CCS_FAST_HOURS    = 12;
  localparam int CCS_MS_PER_HOUR   = 3600000;
  localparam int CCS_TOPOFF_MS     = 1800000;
  localparam int CCS_BLINK_MS      = 500;
  localparam logic [1:0] CCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CCS_RESP_SLVERR = 2'h2;
  // Analog comparator and loop request levels from the power stage.
  typedef struct packed {
    logic ce_n;           // Charge enable pin, active low.
    logic conv_ready;     // Converter has started up.
    logic ts_fault;       // Thermistor sense fault.
    logic below_short;    // Battery below short threshold.
    logic below_lowv;     // Battery below low threshold.
    logic below_rechg;    // Battery below recharge threshold.
    logic below_term;     // Charge current below termination.
    logic cv_loop;        // Constant-voltage loop in control.
    logic thermal_reg;    // Thermal regulation active.
    logic in_over_i;      // Input current at adapter rating.
    logic in_sag_v;       // Input voltage sagging.
    logic vsys_below_min; // System below minimum voltage.
    logic vsys_below_bat; // System below battery voltage.
    logic below_depl;     // Battery below depletion threshold.
  } ccs_sense_t;
  typedef struct packed {
    logic [11:0] charge_current_ma; // Current target of the phase.
    logic        reduce_current;    // Minimum system voltage loop in control.
    logic        input_current_limit_loop;
    logic        input_voltage_limit_loop;
    logic        battery_switch;
    logic [1:0]  recharge_threshold_sel;
  } ccs_drive_t;
endpackage

// *** verilog/ccs_sequencer.sv ***
// Charge cycle sequencer with AXI4-Lite register access.
//
// Overview of operation
// R1: Enabled bit and low pin run cycle autonomously.
// R2: Start needs converter, enables, no faults.
// R3: Terminate on low current, high voltage, no limiting.
// R4: Restart below selectable recharge threshold after done.
// R5: Enable toggle after termination restarts cycle.
// R6: Status pin low charging, high done, blinks fault.
// R7: Status pin disable bit releases the pin.
// R8: Phase codes 000 to 100 per phase.
// R9: 101 reserved, 110 top-off, 111 done.
// R10: Every phase code change pulses interrupt.
// R11: Start phase chosen from sampled battery voltage.
// R12: Trickle, pre, constant current, voltage, top-off.
// R13: Default current by cell count, 2A/1A.
// R14: Default voltage limit by cell count.
// R15: Engage input current or voltage limiting.
// R16: Reduce current when system voltage sags.
// R17: Battery switch on for supplement, off at depletion.
// R18: Limit status bits follow active limiting loops.
// R19: Host may rewrite settings at any time.
// R20: Fast safety timer defaults to twelve hours.
// R21: Timer half rate under limiting if enabled.
// R22: Phase 000 whenever start conditions fail; in done the code keeps 111 unless enable drops or the battery falls below recharge threshold.
`timescale 1ns/10ps
module ccs_sequencer
  import ccs_pkg::*;
#(
  parameter int TICK_CYCLES = CCS_TICK_CYCLES,
  parameter int TRICKLE_MS  = CCS_TRICKLE_HOURS * CCS_MS_PER_HOUR,
  parameter int PRE_MS      = CCS_PRE_HOURS * CCS_MS_PER_HOUR,
  parameter int FAST_MS     = CCS_FAST_HOURS * CCS_MS_PER_HOUR,
  parameter int TOPOFF_MS   = CCS_TOPOFF_MS,
  parameter int BLINK_MS    = CCS_BLINK_MS
) (
  input  wire logic        aclk,          // System clock, 50 MHz.
  input  wire logic        aresetn,       // Synchronous reset, active low.
  input  wire logic [3:0]  s_axi_awaddr,  // Write address.
  input  wire logic        s_axi_awvalid, // Write address valid.
  output logic             s_axi_awready, // Write address ready.
  input  wire logic [31:0] s_axi_wdata,   // Write data.
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes.
  input  wire logic        s_axi_wvalid,  // Write data valid.
  output logic             s_axi_wready,  // Write data ready.
  output logic [1:0]       s_axi_bresp,   // Write response.
  output logic             s_axi_bvalid,  // Write response valid.
  input  wire logic        s_axi_bready,  // Write response ready.
  input  wire logic [3:0]  s_axi_araddr,  // Read address.
  input  wire logic        s_axi_arvalid, // Read address valid.
  output logic             s_axi_arready, // Read address ready.
  output logic [31:0]      s_axi_rdata,   // Read data.
  output logic [1:0]       s_axi_rresp,   // Read response.
  output logic             s_axi_rvalid,  // Read data valid.
  input  wire logic        s_axi_rready,  // Read data ready.
  input  wire ccs_sense_t  sense_i,       // Asynchronous analog levels.
  output ccs_drive_t       drive_o,       // Power stage controls.
  output logic             stat_o,        // Status pin level, always low.
  output logic             stat_oe_n,     // Status pin enable, low drives.
  output logic [2:0]       charge_phase_code, // Present phase code.
  output logic             phase_int      // One-cycle pulse on phase change.
);

  typedef enum logic [7:0] {
    CCS_IDLE    = 8'h01,
    CCS_TRICKLE = 8'h02,
    CCS_PRE     = 8'h04,
    CCS_FAST    = 8'h08,
    CCS_TAPER   = 8'h10,
    CCS_TOPOFF  = 8'h20,
    CCS_DONE    = 8'h40,
    CCS_FAULT   = 8'h80
  } ccs_state_t;

  function automatic logic [11:0] ccs_fast_ma(input logic [1:0] cells);
    ccs_fast_ma = cells[1] ? CCS_I_FAST_HI_MA : CCS_I_FAST_LO_MA;
  endfunction

  function automatic logic [15:0] ccs_vreg_mv(input logic [1:0] cells);
    case (cells)
      2'h0:    ccs_vreg_mv = CCS_V_1S_MV;
      2'h1:    ccs_vreg_mv = CCS_V_2S_MV;
      2'h2:    ccs_vreg_mv = CCS_V_3S_MV;
      default: ccs_vreg_mv = CCS_V_4S_MV;
    endcase
  endfunction

  ccs_sense_t  meta_q, sync_q;
  ccs_state_t  state_q, state_d;
  logic [7:0]  ctrl_q;
  logic [31:0] tick_cnt_q, tmr_q, blink_cnt_q, tmr_limit;
  logic        tick, alt_q, half_q, tmr_fault_q, suppl_q, blink_q, en_prev_q;
  logic [2:0]  phase_d, phase_q;
  logic        int_q, stat_oe_n_q;
  logic        aw_held_q, w_held_q;
  logic [3:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        en, start_ok, limiting, charging, term_ok, stage_change;

  // Analog levels arrive unsynchronised and pass two flops.
  always_ff @(posedge aclk) begin
    meta_q <= sense_i;
    sync_q <= meta_q;
  end

  // Enable from both bit and pin.
  assign en       = ctrl_q[CCS_CTRL_EN] && !sync_q.ce_n;
  // R2: start qualification
  assign start_ok = en && sync_q.conv_ready && !sync_q.ts_fault && !tmr_fault_q;
  assign limiting = drive_o.input_current_limit_loop || drive_o.input_voltage_limit_loop || sync_q.thermal_reg;
  assign charging = state_q inside {CCS_TRICKLE, CCS_PRE, CCS_FAST, CCS_TAPER, CCS_TOPOFF};
  // R3: termination test
  assign term_ok  = sync_q.below_term && !sync_q.below_rechg && !limiting;

  // R1: autonomous cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      CCS_IDLE: begin
        // R11: phase from sampled battery voltage
        if (start_ok) begin
          if (sync_q.below_short) begin
            state_d = CCS_TRICKLE;
          end else if (sync_q.below_lowv) begin
            state_d = CCS_PRE;
          end else begin
            state_d = CCS_FAST;
          end
        end
      end
      // R12: phase sequence
      CCS_TRICKLE: begin
        if (!sync_q.below_short) begin
          state_d = CCS_PRE;
        end
      end
      CCS_PRE: begin
        if (sync_q.below_short) begin
          state_d = CCS_TRICKLE;
        end else if (!sync_q.below_lowv) begin
          state_d = CCS_FAST;
        end
      end
      CCS_FAST: begin
        if (sync_q.below_lowv) begin
          state_d = CCS_PRE;
        end else if (sync_q.cv_loop) begin
          state_d = CCS_TAPER;
        end
      end
      CCS_TAPER: begin
        if (term_ok) begin
          state_d = ctrl_q[CCS_CTRL_TOPOFF] ? CCS_TOPOFF : CCS_DONE;
        end
      end
      CCS_TOPOFF: begin
        if (tmr_q >= tmr_limit) begin
          state_d = CCS_DONE;
        end
      end
      // R4: recharge restart
      CCS_DONE: begin
        if (sync_q.below_rechg) begin
          state_d = CCS_IDLE;
        end
      end
      CCS_FAULT: begin
        if (!sync_q.ts_fault && !tmr_fault_q) begin
          state_d = CCS_IDLE;
        end
      end
      default: state_d = CCS_IDLE;
    endcase
    // R22: lost start conditions
    if (state_q != CCS_IDLE && state_q != CCS_DONE && state_q != CCS_FAULT) begin
      if (sync_q.ts_fault || tmr_fault_q) begin
        state_d = CCS_FAULT;
      end else if (!en || !sync_q.conv_ready) begin
        state_d = CCS_IDLE;
      end
    end
    // R5: enable toggle leaves done
    if ((state_q == CCS_DONE || state_q == CCS_FAULT) && !en) begin
      state_d = CCS_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CCS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // R8: phase codes, R9 covers 110 and 111; 101 is never produced.
  always_comb begin
    case (state_q)
      CCS_TRICKLE: phase_d = CCS_PH_TRICKLE;
      CCS_PRE:     phase_d = CCS_PH_PRE;
      CCS_FAST:    phase_d = CCS_PH_FAST;
      CCS_TAPER:   phase_d = CCS_PH_TAPER;
      CCS_TOPOFF:  phase_d = CCS_PH_TOPOFF;
      CCS_DONE:    phase_d = CCS_PH_DONE;
      default:     phase_d = CCS_PH_NONE;
    endcase
  end

  // R10: interrupt on phase change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= CCS_PH_NONE;
      int_q   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      int_q   <= (phase_d != phase_q);
    end
  end
  assign charge_phase_code = phase_q;
  assign phase_int         = int_q;

  // Millisecond tick divider.
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  // R21: half rate latched while limiting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q <= 1'b1;
      alt_q  <= 1'b0;
    end else begin
      if (!limiting) begin
        half_q <= ctrl_q[CCS_CTRL_HALF];
      end
      if (tick) begin
        alt_q <= !alt_q;
      end
    end
  end

  // R20: timer limits per stage
  always_comb begin
    case (state_q)
      CCS_TRICKLE: tmr_limit = 32'(TRICKLE_MS);
      CCS_PRE:     tmr_limit = 32'(PRE_MS);
      CCS_TOPOFF:  tmr_limit = 32'(TOPOFF_MS);
      default:     tmr_limit = 32'(FAST_MS);
    endcase
  end
  assign stage_change = (state_d != state_q);

  // Safety timer, suspended in supplement mode and restarted each stage.
  always_ff @(posedge aclk) begin
    if (!aresetn || !charging || stage_change) begin
      tmr_q <= 32'h0;
    end else if (tick && !suppl_q && (!(limiting && half_q) || alt_q)) begin
      tmr_q <= tmr_q + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      tmr_fault_q <= 1'b0;
    end else if (charging && state_q != CCS_TOPOFF && tmr_q >= tmr_limit) begin
      tmr_fault_q <= 1'b1;
    end
  end

  // R17: supplement mode switch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      suppl_q <= 1'b0;
    end else if (sync_q.below_depl) begin
      suppl_q <= 1'b0;
    end else if (sync_q.vsys_below_bat) begin
      suppl_q <= 1'b1;
    end
  end

  // Power stage controls, all from flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_o <= '0;
    end else begin
      // R11: phase current, R13 default fast current
      case (state_q)
        CCS_TRICKLE: drive_o.charge_current_ma <= CCS_I_TRICKLE_MA;
        CCS_PRE:     drive_o.charge_current_ma <= CCS_I_PRE_MA;
        CCS_FAST, CCS_TAPER, CCS_TOPOFF: begin
          drive_o.charge_current_ma <= ccs_fast_ma(ctrl_q[CCS_CTRL_CELL_LSB +: 2]);
        end
        default:     drive_o.charge_current_ma <= 12'h000;
      endcase
      // R16: minimum system voltage loop
      drive_o.reduce_current <= charging && sync_q.vsys_below_min;
      // R15: input limiting loops
      drive_o.input_current_limit_loop <= sync_q.in_over_i;
      drive_o.input_voltage_limit_loop <= sync_q.in_sag_v;
      drive_o.battery_switch           <= charging || suppl_q;
      // R4: recharge threshold select
      drive_o.recharge_threshold_sel   <= ctrl_q[CCS_CTRL_RCH_LSB +: 2];
    end
  end

  // Blink divider for the fault indication.
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != CCS_FAULT) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end else if (tick) begin
      if (blink_cnt_q == 32'(BLINK_MS - 1)) begin
        blink_cnt_q <= 32'h0;
        blink_q     <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h1;
      end
    end
  end

  // R6: status pin level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_oe_n_q <= 1'b1;
    end else if (ctrl_q[CCS_CTRL_STATDIS]) begin
      // R7: pin released when disabled
      stat_oe_n_q <= 1'b1;
    end else if (state_q == CCS_FAULT) begin
      stat_oe_n_q <= blink_q;
    end else begin
      stat_oe_n_q <= !charging;
    end
  end
  assign stat_o    = 1'b0;
  assign stat_oe_n = stat_oe_n_q;

  // Write channel: address and data taken in either order.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else if (aw_held_q && w_held_q) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // R19: host writes control at any time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q       <= CCS_CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= CCS_RESP_OKAY;
    end else if (aw_held_q && w_held_q) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_q[3:2] == CCS_OFS_CTRL[3:2]) begin
        s_axi_bresp <= CCS_RESP_OKAY;
        if (w_strb_q[0]) begin
          ctrl_q <= w_data_q[7:0];
        end
      end else if (aw_addr_q[3:2] == CCS_OFS_STATUS[3:2] || aw_addr_q[3:2] == CCS_OFS_DEFAULTS[3:2]
                   || aw_addr_q[3:2] == CCS_OFS_TIMER[3:2]) begin
        s_axi_bresp <= CCS_RESP_OKAY;
      end else begin
        s_axi_bresp <= CCS_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel answers one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= CCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= CCS_RESP_OKAY;
      if (s_axi_araddr[3:2] == CCS_OFS_CTRL[3:2]) begin
        s_axi_rdata <= {24'h0, ctrl_q};
      end else if (s_axi_araddr[3:2] == CCS_OFS_STATUS[3:2]) begin
        // R18: limit status bits
        s_axi_rdata <= {23'h0, suppl_q, tmr_fault_q, sync_q.ts_fault, drive_o.battery_switch,
                        drive_o.input_current_limit_loop, drive_o.input_voltage_limit_loop, phase_q};
      end else if (s_axi_araddr[3:2] == CCS_OFS_DEFAULTS[3:2]) begin
        // R14: default voltage limit
        s_axi_rdata <= {ccs_vreg_mv(ctrl_q[CCS_CTRL_CELL_LSB +: 2]), 4'h0,
                        ccs_fast_ma(ctrl_q[CCS_CTRL_CELL_LSB +: 2])};
      end else begin
        s_axi_rdata <= tmr_q;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Assertions.
  sequence s_term_seen;
    state_q == CCS_TAPER && term_ok && start_ok && !ctrl_q[CCS_CTRL_TOPOFF];
  endsequence

  property p_phase_int;  // R10
    @(posedge aclk) disable iff (!aresetn) $changed(phase_q) |-> int_q;
  endproperty
  a_phase_int: assert property (p_phase_int) else $error("phase change without interrupt");

  property p_term_done;  // R3
    @(posedge aclk) disable iff (!aresetn) s_term_seen ##1 en |-> ##1 phase_q == CCS_PH_DONE;
  endproperty
  a_term_done: assert property (p_term_done) else $error("termination did not report done");

  property p_no_term_limit;  // R3
    @(posedge aclk) disable iff (!aresetn) state_q == CCS_TAPER && limiting && en |=> state_q != CCS_DONE;
  endproperty
  a_no_term_limit: assert property (p_no_term_limit) else $error("termination while limiting");

  property p_disabled_none;  // R22
    @(posedge aclk) disable iff (!aresetn) !en ##1 !en |-> ##1 phase_q == CCS_PH_NONE;
  endproperty
  a_disabled_none: assert property (p_disabled_none) else $error("phase not zero while disabled");

  property p_no_rsvd;  // R9
    @(posedge aclk) disable iff (!aresetn) phase_q != CCS_PH_RSVD;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved phase code seen");

  property p_stat_dis;  // R7
    @(posedge aclk) disable iff (!aresetn) ctrl_q[CCS_CTRL_STATDIS] |=> stat_oe_n;
  endproperty
  a_stat_dis: assert property (p_stat_dis) else $error("status pin driven while disabled");

  property p_stat_chg;  // R6
    @(posedge aclk) disable iff (!aresetn) charging && !ctrl_q[CCS_CTRL_STATDIS] |=> !stat_oe_n;
  endproperty
  a_stat_chg: assert property (p_stat_chg) else $error("status pin not low while charging");

  property p_start_phase;  // R11
    @(posedge aclk) disable iff (!aresetn)
      state_q == CCS_IDLE && start_ok && sync_q.below_short |=> ##1 phase_q == CCS_PH_TRICKLE;
  endproperty
  a_start_phase: assert property (p_start_phase) else $error("wrong starting phase");

  property p_suppl_off;  // R17
    @(posedge aclk) disable iff (!aresetn) sync_q.below_depl |=> !suppl_q;
  endproperty
  a_suppl_off: assert property (p_suppl_off) else $error("supplement kept past depletion");

  property p_ilim;  // R18
    @(posedge aclk) disable iff (!aresetn) sync_q.in_over_i |=> drive_o.input_current_limit_loop;
  endproperty
  a_ilim: assert property (p_ilim) else $error("current limit status not set");

  property p_fast_ma;  // R13
    @(posedge aclk) disable iff (!aresetn)
      state_q == CCS_FAST && !ctrl_q[CCS_CTRL_CELL_LSB + 1] ##1 state_q == CCS_FAST
      |-> drive_o.charge_current_ma == CCS_I_FAST_LO_MA || $changed(ctrl_q);
  endproperty
  a_fast_ma: assert property (p_fast_ma) else $error("fast current default wrong");

endmodule
